/* logic/cpu_state_pkg.sv */
// package: address map, mode codes and shared types for the core state block
package cpu_state_pkg;
  // program space
  localparam logic [11:0] RESERVED_TOP = 12'hADF;
  localparam logic [11:0] SELFTEST_ROM_LO = 12'hAE0;
  localparam logic [11:0] SELFTEST_ROM_HI = 12'hBFF;
  localparam logic [11:0] PROG_ROM_LO = 12'hC00;
  localparam logic [11:0] PROG_ROM_HI = 12'hFF7;
  localparam logic [11:0] VEC_ST_IRQ = 12'hFF8;
  localparam logic [11:0] VEC_ST_RESTART = 12'hFFA;
  localparam logic [11:0] VEC_USER_IRQ = 12'hFFC;
  localparam logic [11:0] VEC_USER_RESTART = 12'hFFE;
  // data space
  localparam logic [7:0] ADDR_PORT_A_VALUE = 8'h00;
  localparam logic [7:0] ADDR_PORT_B_VALUE = 8'h01;
  localparam logic [7:0] ADDR_PORT_C_VALUE = 8'h02;
  localparam logic [7:0] ADDR_PORT_A_DIR = 8'h04;
  localparam logic [7:0] ADDR_PORT_B_DIR = 8'h05;
  localparam logic [7:0] ADDR_PORT_C_DIR = 8'h06;
  localparam logic [7:0] ADDR_TIMER_STATE = 8'h09;
  localparam logic [7:0] DROM_LO = 8'h20;
  localparam logic [7:0] DROM_HI = 8'h5F;
  localparam logic [7:0] RAM_LO = 8'h80;
  localparam logic [7:0] ADDR_POINTER_ONE = 8'h80;
  localparam logic [7:0] ADDR_POINTER_TWO = 8'h81;
  localparam logic [7:0] RAM_HI = 8'h9F;
  localparam logic [7:0] ADDR_PRESCALE = 8'hFD;
  localparam logic [7:0] ADDR_TIMER_COUNT = 8'hFE;
  localparam logic [7:0] ADDR_ACCUMULATOR = 8'hFF;
  // fill values, reset values and sizes
  localparam logic [7:0] ALL_ONES_BYTE = 8'hFF;
  localparam logic [7:0] UNUSED_READ = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam int STACK_DEPTH = 4;
  localparam int RAM_WORDS = 32;
  localparam int SYNC_STAGES = 3;
  // operating modes, one-hot
  typedef enum logic [2:0] {
    MODE_SINGLE = 3'b001,
    MODE_SELFTEST = 3'b010,
    MODE_ROMVERIFY = 3'b100
  } op_mode_e;
  // reset-exit state machine, one-hot
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_FETCH_VEC = 3'b010,
    ST_RUN = 3'b100
  } seq_state_e;
  // pc-control commands from the sequencer
  typedef enum logic [2:0] {
    PC_HOLD = 3'h0,
    PC_LOAD = 3'h1,
    PC_CALL = 3'h2,
    PC_RET = 3'h3,
    PC_IRQ = 3'h4,
    PC_RTI = 3'h5,
    PC_INC = 3'h6
  } pc_cmd_e;
  // alu result for flag updates
  typedef struct packed {
    logic arith;
    logic logical;
    logic carry_out;
    logic bit_test;
    logic bit_val;
    logic rotate;
    logic [7:0] result;
  } alu_flags_s;
  // data-space access
  typedef struct packed {
    logic rd;
    logic wr;
    logic indirect;
    logic use_two;
    logic [7:0] addr;
    logic [7:0] wdata;
  } data_req_s;
  // carry/zero pair
  typedef struct packed {
    logic c;
    logic z;
  } flag_pair_s;
endpackage

/* logic/cpu_state.sv */
// core state: address decode, pc, flag banks, return stack, mode latch
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1 - strap high: latch decoded port A mode
// RULE2 - strap low: single-chip, lines ignored
// RULE3 - normal reset exit loads user restart
// RULE4 - 4096-byte program, 256-byte data space
// RULE5 - program space reserved, self-test, program ROM
// RULE6 - four vectors in top eight bytes
// RULE7 - ports, directions, timer control placement
// RULE8 - data 20h-5Fh is read-only ROM
// RULE9 - RAM 80h-9Fh, pointers are plain RAM
// RULE10 - prescaler, count, accumulator at top
// RULE11 - 8-bit accumulator is alu operand/destination
// RULE12 - indirect addressing uses pointer contents
// RULE13 - 12-bit pc, low byte and nibble
// RULE14 - carry follows alu carry or borrow
// RULE15 - bit test and rotate use carry
// RULE16 - zero flag tracks zero result
// RULE17 - two flag banks, switched on irq/return
// RULE18 - irq bank kept; reset clears both
// RULE19 - push shifts pc into stack top
// RULE20 - pop loads pc, levels move up
// RULE21 - four levels; overpop repeats bottom
// RULE22 - irq pin asynchronous to clock
// RULE23 - irq vector chosen by mode
// RULE24 - unused locations read fixed, ignore writes
// RULE25 - rom writes ignored
module cpu_state
  import cpu_state_pkg::*;
#(
  parameter int PW = 12,
  parameter int DW = 8
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic mode_select_pin_i,
  input wire logic port_a_line6_i,
  input wire logic port_a_line7_i,
  input wire logic irq_n_i,
  input wire logic [2:0] pc_cmd_i,
  input wire logic [PW-1:0] pc_load_i,
  input wire alu_flags_s alu_i,
  input wire data_req_s dreq_i,
  input wire logic [DW-1:0] port_in_a_i,
  input wire logic [DW-1:0] port_in_b_i,
  input wire logic [DW-1:0] port_in_c_i,
  input wire logic [DW-1:0] timer_state_i,
  input wire logic [DW-1:0] prescale_i,
  input wire logic [DW-1:0] timer_count_i,
  input wire logic [DW-1:0] drom_data_i,
  input wire logic [DW-1:0] prom_data_i,
  output logic [PW-1:0] pc_o,
  output logic [DW-1:0] pc_low_byte_o,
  output logic [3:0] pc_high_nibble_o,
  output logic [DW-1:0] prog_data_o,
  output logic [DW-1:0] data_rdata_o,
  output logic [DW-1:0] accumulator_o,
  output logic carry_o,
  output logic zero_o,
  output logic irq_mode_o,
  output logic irq_sync_o,
  output logic [2:0] op_mode_o,
  output logic running_o,
  output logic [DW-1:0] port_a_direction_o,
  output logic [DW-1:0] port_b_direction_o,
  output logic [DW-1:0] port_c_direction_o,
  output logic [DW-1:0] port_a_value_o,
  output logic [DW-1:0] port_b_value_o,
  output logic [DW-1:0] port_c_value_o,
  output logic timer_state_wr_o,
  output logic prescale_wr_o,
  output logic timer_count_wr_o
);

  // whole module state
  typedef struct packed {
    seq_state_e seq;
    op_mode_e mode;
    logic [PW-1:0] pc;
    logic [STACK_DEPTH-1:0][PW-1:0] stack;
    flag_pair_s prog_flags;
    flag_pair_s irq_flags;
    logic in_irq;
    logic [DW-1:0] acc;
    logic [RAM_WORDS-1:0][DW-1:0] ram;
    logic [DW-1:0] pa, pb, pc_port, da, db, dc;
    logic [SYNC_STAGES-1:0] irq_sync;
    logic irq_lvl;
    logic [DW-1:0] rdata;
    logic [DW-1:0] pdata;
  } state_s;

  state_s state_reg, state_next;

  // program-space decode: reserved reads all ones
  function automatic logic [DW-1:0] prog_read(input logic [PW-1:0] a,
                                              input logic [DW-1:0] rom);
    if (a <= RESERVED_TOP) begin
      prog_read = ALL_ONES_BYTE; // RULE5
    end else begin
      prog_read = rom; // RULE5 RULE6
    end
  endfunction

  // ram index from a data-space address
  function automatic logic [4:0] ram_idx(input logic [7:0] a);
    ram_idx = a[4:0];
  endfunction

  // flag update on the given pair
  function automatic flag_pair_s upd_flags(input flag_pair_s f,
                                           input alu_flags_s u);
    upd_flags = f;
    if (u.arith) begin
      upd_flags.c = u.carry_out; // RULE14
    end
    if (u.bit_test) begin
      upd_flags.c = u.bit_val; // RULE15
    end
    if (u.rotate) begin
      upd_flags.c = u.carry_out; // RULE15 bit shifted out through carry
    end
    if (u.arith || u.logical) begin
      upd_flags.z = (u.result == 8'h00); // RULE16
    end
  endfunction

  logic [7:0] eff_addr;
  logic [DW-1:0] rd_val;

  // next-state logic
  always_comb begin
    state_next = state_reg;
    eff_addr = dreq_i.addr;
    rd_val = UNUSED_READ;
    // irq pin passes three flops, change taken when stages 2 and 3 agree
    state_next.irq_sync = {state_reg.irq_sync[1:0], ~irq_n_i}; // RULE22
    if (state_reg.irq_sync[1] == state_reg.irq_sync[2]) begin
      state_next.irq_lvl = state_reg.irq_sync[2];
    end
    // indirect addressing through a pointer
    if (dreq_i.indirect) begin
      eff_addr = dreq_i.use_two ? state_reg.ram[1] : state_reg.ram[0]; // RULE12
    end
    // data-space read decode
    case (1'b1)
      eff_addr == ADDR_PORT_A_VALUE: rd_val = port_in_a_i; // RULE7
      eff_addr == ADDR_PORT_B_VALUE: rd_val = port_in_b_i;
      eff_addr == ADDR_PORT_C_VALUE: rd_val = port_in_c_i;
      eff_addr == ADDR_PORT_A_DIR: rd_val = state_reg.da;
      eff_addr == ADDR_PORT_B_DIR: rd_val = state_reg.db;
      eff_addr == ADDR_PORT_C_DIR: rd_val = state_reg.dc;
      eff_addr == ADDR_TIMER_STATE: rd_val = timer_state_i;
      (eff_addr >= DROM_LO && eff_addr <= DROM_HI): rd_val = drom_data_i; // RULE8
      (eff_addr >= RAM_LO && eff_addr <= RAM_HI):
        rd_val = state_reg.ram[ram_idx(eff_addr)]; // RULE9
      eff_addr == ADDR_PRESCALE: rd_val = prescale_i; // RULE10
      eff_addr == ADDR_TIMER_COUNT: rd_val = timer_count_i; // RULE10
      eff_addr == ADDR_ACCUMULATOR: rd_val = state_reg.acc; // RULE10
      default: rd_val = UNUSED_READ; // RULE24
    endcase
    if (dreq_i.rd) begin
      state_next.rdata = rd_val;
    end
    // data-space write decode; rom and unused are ignored
    if (dreq_i.wr && state_reg.seq == ST_RUN) begin
      case (1'b1)
        eff_addr == ADDR_PORT_A_VALUE: state_next.pa = dreq_i.wdata; // RULE7
        eff_addr == ADDR_PORT_B_VALUE: state_next.pb = dreq_i.wdata;
        eff_addr == ADDR_PORT_C_VALUE: state_next.pc_port = dreq_i.wdata;
        eff_addr == ADDR_PORT_A_DIR: state_next.da = dreq_i.wdata;
        eff_addr == ADDR_PORT_B_DIR: state_next.db = dreq_i.wdata;
        eff_addr == ADDR_PORT_C_DIR: state_next.dc = dreq_i.wdata;
        (eff_addr >= RAM_LO && eff_addr <= RAM_HI):
          state_next.ram[ram_idx(eff_addr)] = dreq_i.wdata; // RULE9
        eff_addr == ADDR_ACCUMULATOR: state_next.acc = dreq_i.wdata; // RULE10
        default: state_next.acc = state_next.acc; // RULE24 RULE25
      endcase
    end
    // alu results land in the accumulator and the active flag bank
    if (state_reg.seq == ST_RUN && (alu_i.arith || alu_i.logical ||
        alu_i.rotate)) begin
      state_next.acc = alu_i.result; // RULE11
    end
    if (state_reg.seq == ST_RUN) begin
      if (state_reg.in_irq) begin
        state_next.irq_flags = upd_flags(state_reg.irq_flags, alu_i); // RULE17
      end else begin
        state_next.prog_flags = upd_flags(state_reg.prog_flags, alu_i);
      end
    end
    // sequencer and pc
    case (state_reg.seq)
      ST_RESET: begin
        // latch mode at reset exit
        if (mode_select_pin_i) begin
          case ({port_a_line7_i, port_a_line6_i}) // RULE1
            2'b01: state_next.mode = MODE_SELFTEST;
            2'b10: state_next.mode = MODE_ROMVERIFY;
            default: state_next.mode = MODE_SINGLE;
          endcase
        end else begin
          state_next.mode = MODE_SINGLE; // RULE2
        end
        state_next.seq = ST_FETCH_VEC;
      end
      ST_FETCH_VEC: begin
        // restart vector: pc loaded directly with the vector address chosen by mode
        state_next.pc = (state_reg.mode == MODE_SELFTEST) ?
          VEC_ST_RESTART : VEC_USER_RESTART; // RULE3
        state_next.seq = ST_RUN;
      end
      ST_RUN: begin
        case (pc_cmd_e'(pc_cmd_i))
          PC_INC: state_next.pc = state_reg.pc + 12'h001; // RULE4
          PC_LOAD: state_next.pc = pc_load_i; // RULE13
          PC_CALL: begin
            state_next.stack = {state_reg.stack[STACK_DEPTH-2:0],
                                state_reg.pc}; // RULE19
            state_next.pc = pc_load_i;
          end
          PC_IRQ: begin
            state_next.stack = {state_reg.stack[STACK_DEPTH-2:0],
                                state_reg.pc}; // RULE19
            state_next.in_irq = 1'b1; // RULE17 RULE18
            state_next.pc = (state_reg.mode == MODE_SELFTEST) ?
              VEC_ST_IRQ : VEC_USER_IRQ; // RULE23
          end
          PC_RET, PC_RTI: begin
            state_next.pc = state_reg.stack[0]; // RULE20
            state_next.stack = {state_reg.stack[STACK_DEPTH-1],
                                state_reg.stack[STACK_DEPTH-1:1]}; // RULE21
            if (pc_cmd_e'(pc_cmd_i) == PC_RTI) begin
              state_next.in_irq = 1'b0; // RULE17
            end
          end
          default: state_next.pc = state_reg.pc;
        endcase
      end
      default: state_next.seq = ST_RESET;
    endcase
    state_next.pdata = prog_read(state_next.pc, prom_data_i); // RULE5
  end

  // state register, synchronous reset
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_reg <= '0;
      state_reg.seq <= ST_RESET;
      state_reg.mode <= MODE_SINGLE;
      state_reg.pc <= PC_RESET;
      state_reg.prog_flags <= '0; // RULE18
      state_reg.irq_flags <= '0; // RULE18
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs
  assign pc_o = state_reg.pc;
  assign pc_low_byte_o = state_reg.pc[7:0]; // RULE13
  assign pc_high_nibble_o = state_reg.pc[11:8]; // RULE13
  assign prog_data_o = state_reg.pdata;
  assign data_rdata_o = state_reg.rdata;
  assign accumulator_o = state_reg.acc;
  assign carry_o = state_reg.in_irq ? state_reg.irq_flags.c :
                   state_reg.prog_flags.c; // RULE17
  assign zero_o = state_reg.in_irq ? state_reg.irq_flags.z :
                  state_reg.prog_flags.z; // RULE17
  assign irq_mode_o = state_reg.in_irq;
  assign irq_sync_o = state_reg.irq_lvl;
  assign op_mode_o = state_reg.mode;
  assign running_o = (state_reg.seq == ST_RUN);
  assign port_a_direction_o = state_reg.da;
  assign port_b_direction_o = state_reg.db;
  assign port_c_direction_o = state_reg.dc;
  assign port_a_value_o = state_reg.pa;
  assign port_b_value_o = state_reg.pb;
  assign port_c_value_o = state_reg.pc_port;
  assign timer_state_wr_o = dreq_i.wr && running_o &&
                            eff_addr == ADDR_TIMER_STATE;
  assign prescale_wr_o = dreq_i.wr && running_o && eff_addr == ADDR_PRESCALE;
  assign timer_count_wr_o = dreq_i.wr && running_o &&
                            eff_addr == ADDR_TIMER_COUNT;

  // assertions
  push_shift_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    running_o && pc_cmd_i == PC_CALL |=> state_reg.stack[0] == $past(pc_o))
    else $error("push did not store pc"); // RULE19
  pop_load_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    running_o && pc_cmd_i == PC_RET |=> pc_o == $past(state_reg.stack[0]))
    else $error("pop did not load pc"); // RULE20
  bottom_keep_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    running_o && pc_cmd_i == PC_RET |=>
    state_reg.stack[3] == $past(state_reg.stack[3]))
    else $error("bottom level lost"); // RULE21
  irq_vec_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    running_o && pc_cmd_i == PC_IRQ |=> irq_mode_o &&
    pc_o == ((op_mode_o == MODE_SELFTEST) ? VEC_ST_IRQ : VEC_USER_IRQ))
    else $error("wrong irq vector"); // RULE23
  rti_bank_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    running_o && pc_cmd_i == PC_RTI |=> !irq_mode_o)
    else $error("rti kept irq bank"); // RULE17
  reset_vec_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $rose(running_o) && op_mode_o == MODE_SINGLE |-> pc_o == VEC_USER_RESTART)
    else $error("restart vector wrong"); // RULE3
  strap_low_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !sys_rst_i && state_reg.seq == ST_RESET && !mode_select_pin_i |=>
    op_mode_o == MODE_SINGLE)
    else $error("strap low not single"); // RULE2
  strap_high_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !sys_rst_i && state_reg.seq == ST_RESET && mode_select_pin_i &&
    {port_a_line7_i, port_a_line6_i} == 2'b01 |=> op_mode_o == MODE_SELFTEST)
    else $error("strap decode wrong"); // RULE1
  reserved_ones_a: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    !sys_rst_i && state_next.pc <= RESERVED_TOP |=>
    prog_data_o == ALL_ONES_BYTE)
    else $error("reserved not all ones"); // RULE5
  irq_bank_keep_a: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    !irq_mode_o ##1 irq_mode_o |-> state_reg.irq_flags ==
    $past(state_reg.irq_flags))
    else $error("irq flags cleared on entry"); // RULE18
  zero_flag_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    running_o && !irq_mode_o && alu_i.logical && !alu_i.arith &&
    pc_cmd_i != PC_IRQ |=> zero_o == ($past(alu_i.result) == 8'h00))
    else $error("zero flag wrong"); // RULE16
  carry_arith_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    running_o && !irq_mode_o && alu_i.arith && !alu_i.bit_test &&
    !alu_i.rotate && pc_cmd_i != PC_IRQ |=> carry_o == $past(alu_i.carry_out))
    else $error("carry flag wrong"); // RULE14

  // flag, accumulator, pc and read-path checks
  bit_test_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    running_o && !irq_mode_o && alu_i.bit_test && !alu_i.rotate &&
    pc_cmd_i != PC_IRQ |=> carry_o == $past(alu_i.bit_val))
    else $error("bit test carry wrong"); // RULE15
  rotate_carry_a: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) running_o && !irq_mode_o && alu_i.rotate &&
    pc_cmd_i != PC_IRQ |=> carry_o == $past(alu_i.carry_out))
    else $error("rotate carry wrong"); // RULE15
  acc_alu_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    running_o && (alu_i.arith || alu_i.logical || alu_i.rotate) |=>
    accumulator_o == $past(alu_i.result))
    else $error("alu result not in accumulator"); // RULE11
  flags_reset_a: assert property (@(posedge core_clk_i)
    $fell(sys_rst_i) |-> !carry_o && !zero_o)
    else $error("flags not cleared by reset"); // RULE18
  acc_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    dreq_i.rd && !dreq_i.indirect && dreq_i.addr == ADDR_ACCUMULATOR |=>
    data_rdata_o == $past(accumulator_o))
    else $error("accumulator read wrong"); // RULE10
  unused_read_a: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) dreq_i.rd && !dreq_i.indirect &&
    dreq_i.addr == 8'h03 |=> data_rdata_o == UNUSED_READ)
    else $error("unused location read wrong"); // RULE24
  pc_inc_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    running_o && pc_cmd_i == PC_INC |=>
    pc_o == $past(pc_o) + 12'h001)
    else $error("pc increment wrong"); // RULE4

  call_cov: cover property (@(posedge core_clk_i) running_o &&
    pc_cmd_i == PC_CALL);
  irq_cov: cover property (@(posedge core_clk_i) running_o &&
    pc_cmd_i == PC_IRQ);
  overpop_cov: cover property (@(posedge core_clk_i) running_o &&
    pc_cmd_i == PC_RET ##1 pc_cmd_i == PC_RET ##1 pc_cmd_i == PC_RET
    ##1 pc_cmd_i == PC_RET ##1 pc_cmd_i == PC_RET);
  selftest_cov: cover property (@(posedge core_clk_i)
    op_mode_o == MODE_SELFTEST);
  rti_cov: cover property (@(posedge core_clk_i) running_o &&
    pc_cmd_i == PC_RTI);

endmodule
`default_nettype wire

/* test/strap_irq_model.sv */
// partner model: mode straps and an interrupt source free of the clock
`timescale 1ns/1ps
`default_nettype none
module strap_irq_model (
  input wire logic [2:0] strap_cfg_i,
  input wire logic irq_req_i,
  output logic mode_select_pin_o,
  output logic port_a_line7_o,
  output logic port_a_line6_o,
  output var logic irq_n_o
);
  // straps are plain levels that stay put across reset exit
  assign mode_select_pin_o = strap_cfg_i[2];
  assign port_a_line7_o = strap_cfg_i[1];
  assign port_a_line6_o = strap_cfg_i[0];
  // pin moves at an odd offset, unrelated to the core clock
  initial begin
    irq_n_o = 1'b1;
    forever begin
      @(irq_req_i);
      #7.3 irq_n_o = ~irq_req_i;
    end
  end
endmodule
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the core state block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cpu_state_pkg::*;
  typedef struct {int due; int sel; logic [11:0] val;} note_s;
  localparam logic [2:0] CFG [5] = '{3'b001, 3'b101, 3'b110, 3'b111, 3'b100};
  localparam logic [2:0] MD [5] = '{3'b001, 3'b010, 3'b100, 3'b001, 3'b001};
  localparam logic [7:0] HOLE [6] = '{8'h03, 8'h07, 8'h0A, 8'h60, 8'hA0, 8'hFC};
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [2:0] strap_cfg = 3'b000;
  logic irq_req = 1'b0;
  logic msp, l6, l7, irq_n;
  logic [2:0] pc_cmd = 3'h0;
  logic [11:0] pc_load = 12'h000;
  alu_flags_s alu = '0;
  data_req_s dreq = '0;
  logic [7:0] ext [8] = '{default: 8'h00};
  logic [11:0] pc;
  logic [7:0] pc_low_byte, pdata, rdata, acc, dir_a, dir_b, dir_c;
  logic [7:0] val_a, val_b, val_c;
  logic [3:0] pc_high_nibble;
  logic carry, zero, irq_mode, irq_sync, running, ts_wr, ps_wr, tc_wr;
  logic [2:0] op_mode;
  int cyc = 0;
  int err_total = 0;
  int n_compared = 0;
  note_s q[$];

  strap_irq_model i_partner (.strap_cfg_i(strap_cfg), .irq_req_i(irq_req),
    .mode_select_pin_o(msp), .port_a_line7_o(l7), .port_a_line6_o(l6),
    .irq_n_o(irq_n));
  cpu_state i_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .mode_select_pin_i(msp), .port_a_line6_i(l6), .port_a_line7_i(l7),
    .irq_n_i(irq_n), .pc_cmd_i(pc_cmd), .pc_load_i(pc_load), .alu_i(alu),
    .dreq_i(dreq), .port_in_a_i(ext[0]), .port_in_b_i(ext[1]),
    .port_in_c_i(ext[2]), .timer_state_i(ext[3]), .prescale_i(ext[4]),
    .timer_count_i(ext[5]), .drom_data_i(ext[6]), .prom_data_i(ext[7]),
    .pc_o(pc), .pc_low_byte_o(pc_low_byte), .pc_high_nibble_o(pc_high_nibble),
    .prog_data_o(pdata), .data_rdata_o(rdata), .accumulator_o(acc),
    .carry_o(carry), .zero_o(zero), .irq_mode_o(irq_mode),
    .irq_sync_o(irq_sync), .op_mode_o(op_mode), .running_o(running),
    .port_a_direction_o(dir_a), .port_b_direction_o(dir_b),
    .port_c_direction_o(dir_c), .port_a_value_o(val_a),
    .port_b_value_o(val_b), .port_c_value_o(val_c),
    .timer_state_wr_o(ts_wr), .prescale_wr_o(ps_wr),
    .timer_count_wr_o(tc_wr));

  // clock and edge counter
  always #12.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) cyc <= cyc + 1;

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic note(input int sel, input logic [11:0] v, input int d);
    q.push_back('{cyc + d, sel, v});
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one request of every kind per edge, all launched together
  task automatic step(input pc_cmd_e c, input logic [11:0] ld,
                      input data_req_s r, input alu_flags_s a);
    @(posedge core_clk_i);
    pc_cmd <= c;
    pc_load <= ld;
    dreq <= r;
    alu <= a;
  endtask

  function automatic alu_flags_s al(logic ar, logic lg, logic co, logic bt,
                                    logic bv, logic [7:0] res);
    return '{ar, lg, co, bt, bv, 1'b0, res};
  endfunction

  task automatic cmd(input pc_cmd_e c, input logic [11:0] ld);
    step(c, ld, '0, '0);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
    step(PC_HOLD, 12'h000, '{1'b0, 1'b1, 1'b0, 1'b0, ad, wd}, '0);
  endtask

  task automatic rd(input logic [7:0] ad, input logic ind, input logic two,
                    input int sel, input logic [7:0] e);
    step(PC_HOLD, 12'h000, '{1'b1, 1'b0, ind, two, ad, 8'h00}, '0);
    note(sel, {4'h0, e}, 2);
  endtask

  task automatic do_reset(input int i);
    @(posedge core_clk_i);
    strap_cfg <= CFG[i];
    sys_rst_i <= 1'b1;
    pc_cmd <= PC_HOLD;
    dreq <= '0;
    alu <= '0;
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    note(8, {8'h01, 1'b1, MD[i]}, 3);
    note(0, MD[i] == MODE_SELFTEST ? 12'hFFA : 12'hFFE, 3);
    note(22, 12'h000, 3);
    repeat (2) @(posedge core_clk_i);
  endtask

  // compare every due note against the settled outputs
  always @(negedge core_clk_i) begin
    while (q.size() > 0 && q[0].due <= cyc) begin
      case (q[0].sel)
        0: check(pc, q[0].val);
        1: check(pc, q[0].val);
        2: check(pc, q[0].val);
        3: check({pc_high_nibble, pc_low_byte}, q[0].val);
        4: check(carry, q[0].val);
        5: check(zero, q[0].val);
        6: check(carry, q[0].val);
        7: check(irq_mode, q[0].val);
        8: check({8'h01, running, op_mode}, q[0].val);
        9: check(rdata, q[0].val);
        10: check(rdata, q[0].val);
        11: check(rdata, q[0].val);
        12: check(acc, q[0].val);
        13: check(dir_a, q[0].val);
        14: check(dir_b, q[0].val);
        15: check(dir_c, q[0].val);
        16: check({ts_wr, ps_wr, tc_wr}, q[0].val);
        17: check(pdata, q[0].val);
        18: check(irq_sync, q[0].val);
        19: check(val_a, q[0].val);
        20: check(rdata, q[0].val);
        21: check(rdata, q[0].val);
        22: check({carry, zero}, q[0].val);
        24: check(val_b, q[0].val);
        25: check(val_c, q[0].val);
        26: check(pc, q[0].val);
        default: check(carry, q[0].val);
      endcase
      void'(q.pop_front());
    end
  end

  // hang guard
  initial begin
    #75000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    logic [11:0] tg [5];
    logic [7:0] r;
    logic s;
    void'($urandom(21515));
    @(posedge core_clk_i);
    foreach (ext[k]) ext[k] <= 8'($urandom);
    r = 8'($urandom) | 8'h01;
    // every strap setting, its restart vector, and its interrupt vector except in rom-verify mode
    for (int i = 0; i < 5; i++) begin
      do_reset(i);
      if (MD[i] != MODE_ROMVERIFY) begin
        cmd(PC_IRQ, 12'h000);
        note(2, MD[i] == MODE_SELFTEST ? 12'hFF8 : 12'hFFC, 2);
        note(7, 12'h001, 2);
        note(6, 12'h000, 2);
        step(PC_HOLD, 12'h000, '0, al(1, 0, 1, 0, 0, r));
        cmd(PC_RTI, 12'h000);
      end
    end
    // flag updates in the program flag bank
    step(PC_HOLD, 12'h000, '0, al(1, 0, 1, 0, 0, 8'h00));
    note(4, 12'h001, 2);
    note(5, 12'h001, 2);
    step(PC_HOLD, 12'h000, '0, al(1, 0, 0, 0, 0, r));
    note(22, 12'h000, 2);
    note(12, {4'h0, r}, 2);
    step(PC_HOLD, 12'h000, '0, al(0, 1, 0, 0, 0, 8'h00));
    note(5, 12'h001, 2);
    step(PC_HOLD, 12'h000, '0, '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, r});
    note(23, 12'h001, 2);
    step(PC_HOLD, 12'h000, '0, al(0, 0, 0, 1, 0, 8'h00));
    note(23, 12'h000, 2);
    // irq bank still holds what the last service routine left
    cmd(PC_IRQ, 12'h000);
    note(22, 12'h002, 2);
    step(PC_HOLD, 12'h000, '0, al(1, 0, 1, 0, 0, r));
    cmd(PC_RTI, 12'h000);
    note(22, 12'h001, 2);
    cmd(PC_IRQ, 12'h000);
    note(22, 12'h002, 2);
    cmd(PC_RTI, 12'h000);
    // five calls back to back, then six returns
    cmd(PC_LOAD, 12'hC00);
    cmd(PC_INC, 12'h000);
    note(26, 12'hC01, 2);
    for (int i = 0; i < 5; i++) begin
      tg[i] = 12'hC00 + 12'($urandom % 1016);
      cmd(PC_CALL, tg[i]);
      note(1, tg[i], 2);
    end
    for (int i = 0; i < 6; i++) begin
      cmd(PC_RET, 12'h000);
      note(3, tg[i < 4 ? 3 - i : 0], 2);
    end
    // program space: reserved area, edge, program rom
    foreach (tg[i]) begin
      if (i < 3) begin
        cmd(PC_LOAD, i == 0 ? 12'h000 : i == 1 ? RESERVED_TOP : 12'hD55);
        cmd(PC_HOLD, 12'h000);
        note(17, i == 2 ? {4'h0, ext[7]} : 12'h0FF, 2);
        cmd(PC_HOLD, 12'h000);
      end
    end
    // data space map
    wr(ADDR_PORT_A_DIR, r);
    note(13, {4'h0, r}, 2);
    wr(ADDR_PORT_B_DIR, ~r);
    note(14, {4'h0, ~r}, 2);
    wr(ADDR_PORT_C_DIR, r ^ 8'h5A);
    note(15, {4'h0, r ^ 8'h5A}, 2);
    wr(ADDR_PORT_A_VALUE, r ^ 8'hA5);
    note(19, {4'h0, r ^ 8'hA5}, 2);
    wr(ADDR_PORT_B_VALUE, ~r);
    note(24, {4'h0, ~r}, 2);
    wr(ADDR_PORT_C_VALUE, r);
    note(25, {4'h0, r}, 2);
    foreach (HOLE[k]) begin
      wr(HOLE[k], r);
      rd(HOLE[k], 1'b0, 1'b0, 10, UNUSED_READ);
    end
    wr(ADDR_POINTER_ONE, RAM_HI);
    wr(RAM_HI, r);
    rd(8'h00, 1'b1, 1'b0, 20, r);
    wr(ADDR_POINTER_TWO, 8'h85);
    wr(8'h85, ~r);
    rd(8'h00, 1'b1, 1'b1, 20, ~r);
    rd(ADDR_POINTER_ONE, 1'b0, 1'b0, 9, RAM_HI);
    wr(8'h30, r);
    rd(8'h30, 1'b0, 1'b0, 11, ext[6]);
    wr(ADDR_ACCUMULATOR, r ^ 8'h3C);
    note(12, {4'h0, r ^ 8'h3C}, 2);
    rd(ADDR_ACCUMULATOR, 1'b0, 1'b0, 9, r ^ 8'h3C);
    wr(ADDR_TIMER_STATE, r);
    note(16, 12'h004, 1);
    wr(ADDR_PRESCALE, r);
    note(16, 12'h002, 1);
    wr(ADDR_TIMER_COUNT, r);
    note(16, 12'h001, 1);
    rd(ADDR_PRESCALE, 1'b0, 1'b0, 21, ext[4]);
    rd(ADDR_TIMER_COUNT, 1'b0, 1'b0, 21, ext[5]);
    rd(ADDR_TIMER_STATE, 1'b0, 1'b0, 21, ext[3]);
    cmd(PC_HOLD, 12'h000);
    // interrupt pin reaches the core through the synchroniser
    @(negedge core_clk_i);
    s = irq_sync;
    irq_req = 1'b1;
    note(18, {11'h000, ~s}, 5);
    repeat (8) @(negedge core_clk_i);
    irq_req = 1'b0;
    repeat (10) @(posedge core_clk_i);
    tally_and_finish();
  end
endmodule
`default_nettype wire
